//--- rtl/pmrc_top.sv
// power mode and reset sequencer with an apb register slave.
// assumes apb master on core_clk, wake and reset events synchronous.
`timescale 1ns/1ps
module pmrc_top
  import pmrc_pkg::*;
#(
  parameter int HOLD_CYCLES =
    (`PMRC_RST_HOLD_NS + `PMRC_CLK_NS - 1) / `PMRC_CLK_NS,
  parameter int NUM_PERIPH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic any_irq,
  input wire logic wake_tmr4,
  input wire logic wake_spi,
  input wire logic wake_i2c,
  input wire logic wake_port_match,
  input wire logic cmp0_out,
  input wire logic wake_clu,
  input wire logic rst_pin_req,
  input wire logic rst_cmp_req,
  input wire logic rst_supply_req,
  input wire logic rst_wdt_req,
  input wire logic rst_mcd_req,
  input wire logic rst_flash_req,
  input wire logic [NUM_PERIPH-1:0] periph_busy,
  output logic core_halt,
  output logic core_rst,
  output logic core_clk_gate_n,
  output logic [NUM_PERIPH-1:0] periph_clk_en,
  output logic hfo_first_en,
  output logic hfo_second_en,
  output logic lfo_timer_en,
  output logic reg_low_bias,
  output logic power_nets_off,
  output logic pin_hold,
  output logic port_force_default,
  output logic port_latch_one,
  output logic port_open_drain,
  output logic port_pullup_en,
  output logic retain_analog,
  output logic reset_pin_n_o,
  output logic reset_pin_n_oe,
  output logic wdt_enable,
  output logic [15:0] pc_reset_value,
  output logic ram_clear,
  output logic core_clock_source
);
  // ****************************************
  // state and registers
  // ****************************************
  pmrc_state_e state_ff, nxt_state;
  logic idle_ff, stop_ff, susp_ff, snz_ff, sdsel_ff, clksel_ff;
  logic retn_ff, reset_is_por_ff, reset_drive_ff;
  logic [1:0] stat_ff, mask_ff;
  logic [NUM_PERIPH-1:0] pgate_ff;
  logic [2:0] rsrc_ff;
  logic cmp0_d_ff;
  logic sw_rst;
  logic hold_done;
  logic wr, rd;
  logic cmp0_fall, periph_wake, any_rst, drive_src;
  pmrc_src_e src;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign sw_rst = wr && (paddr == `PMRC_OFF_SWRST) && pwdata[0];

  // ****************************************
  // event detection
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmp0_d_ff <= 1'b0;
    end else if (clk_en) begin
      cmp0_d_ff <= cmp0_out;
    end
  end

  assign cmp0_fall = cmp0_d_ff && !cmp0_out;
  assign periph_wake = wake_tmr4 || wake_spi || wake_i2c || // R4
    wake_port_match || cmp0_fall || wake_clu;
  assign any_rst = rst_pin_req || rst_cmp_req || rst_supply_req || // R14
    sw_rst || rst_wdt_req || rst_mcd_req || rst_flash_req;
  assign drive_src = rst_supply_req; // R12

  // lowest number wins; power-on is the async rst itself
  always_comb begin
    src = PMRC_SRC_FLASH;
    if (rst_pin_req) src = PMRC_SRC_PIN;
    else if (rst_cmp_req) src = PMRC_SRC_CMP;
    else if (sw_rst) src = PMRC_SRC_SW;
    else if (rst_supply_req) src = PMRC_SRC_SUPPLY;
    else if (rst_wdt_req) src = PMRC_SRC_WDT;
    else if (rst_mcd_req) src = PMRC_SRC_MCD;
  end

  // ****************************************
  // mode sequencer
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PMRC_RUN: begin
        if (idle_ff) nxt_state = PMRC_IDLE; // R1
        else if (susp_ff || snz_ff) nxt_state = PMRC_LOWP; // R3 R5
        else if (stop_ff) nxt_state = PMRC_OFF; // R6 R7
      end
      PMRC_IDLE: begin
        if (any_irq) nxt_state = PMRC_RUN; // R1
      end
      PMRC_LOWP: begin
        if (periph_wake) nxt_state = PMRC_RUN; // R4
      end
      PMRC_OFF: nxt_state = PMRC_OFF;
      PMRC_RESET: begin
        if (hold_done) nxt_state = PMRC_RUN; // R13
      end
      default: nxt_state = PMRC_RESET;
    endcase
    // any source resets; shutdown leaves only on the pin
    if (state_ff == PMRC_OFF && sdsel_ff) begin
      if (rst_pin_req) nxt_state = PMRC_RESET; // R7
    end else if (any_rst) begin
      nxt_state = PMRC_RESET; // R6 R14
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= PMRC_RESET;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  pmrc_hold_cnt #(.CYCLES(HOLD_CYCLES)) u_hold (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .run(state_ff == PMRC_RESET),
    .done(hold_done)
  );

  // ****************************************
  // reset cause bookkeeping
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsrc_ff <= PMRC_SRC_POR;
      reset_is_por_ff <= 1'b1;
      reset_drive_ff <= 1'b1;
    end else if (clk_en) begin
      if (nxt_state == PMRC_RESET && state_ff != PMRC_RESET) begin
        rsrc_ff <= src;
        reset_is_por_ff <= 1'b0;
        reset_drive_ff <= drive_src; // R12
      end else if (state_ff == PMRC_RESET && hold_done) begin
        reset_drive_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // a system reset clears all mode bits; retention is por-only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idle_ff <= 1'b0;
      stop_ff <= 1'b0;
      susp_ff <= 1'b0;
      snz_ff <= 1'b0;
      sdsel_ff <= 1'b0;
      clksel_ff <= 1'b0;
      pgate_ff <= '0;
    end else if (clk_en) begin
      if (state_ff == PMRC_RESET) begin
        idle_ff <= 1'b0; // R8
        stop_ff <= 1'b0;
        susp_ff <= 1'b0;
        snz_ff <= 1'b0;
        sdsel_ff <= 1'b0;
        clksel_ff <= 1'b0; // R13
        pgate_ff <= '0;
      end else begin
        if (wr && paddr == `PMRC_OFF_PWR0) begin
          idle_ff <= pwdata[`PMRC_PWR0_IDLE];
          stop_ff <= pwdata[`PMRC_PWR0_STOP];
        end
        // suspend entry needs the first oscillator selected
        if (wr && paddr == `PMRC_OFF_PWR1 && !clksel_ff) begin // R2
          susp_ff <= pwdata[`PMRC_PWR1_SUSP];
          snz_ff <= pwdata[`PMRC_PWR1_SNZ];
        end
        if (wr && paddr == `PMRC_OFF_REGC) begin
          sdsel_ff <= pwdata[`PMRC_REGC_SDSEL];
        end
        if (wr && paddr == `PMRC_OFF_CLK) begin
          clksel_ff <= pwdata[`PMRC_CLK_HFO1];
        end
        if (wr && paddr == `PMRC_OFF_PGATE) begin
          pgate_ff <= pwdata[NUM_PERIPH-1:0];
        end
        if (state_ff == PMRC_IDLE && any_irq) begin
          idle_ff <= 1'b0; // R16
        end
        if (state_ff == PMRC_LOWP && periph_wake) begin
          susp_ff <= 1'b0; // R16
          snz_ff <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      retn_ff <= 1'b0;
    end else if (clk_en) begin
      if (wr && paddr == `PMRC_OFF_RETN) begin
        retn_ff <= pwdata[0]; // R11
      end
    end
  end

  // ****************************************
  // interrupt status, read-to-clear
  // ****************************************
  logic stat_rd;
  logic [1:0] stat_set;
  assign stat_rd = rd && paddr == `PMRC_OFF_STAT;
  // bit0 counts every wake, from idle as well as from suspend or snooze
  assign stat_set = {state_ff == PMRC_RESET && hold_done,
                     (state_ff == PMRC_LOWP && periph_wake) ||
                     (state_ff == PMRC_IDLE && any_irq)};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat_ff <= 2'h0;
      mask_ff <= 2'h0;
    end else if (clk_en) begin
      // a new event wins over the clearing read
      stat_ff <= (stat_rd ? 2'h0 : stat_ff) | stat_set;
      if (wr && paddr == `PMRC_OFF_MASK) mask_ff <= pwdata[1:0];
    end
  end

  assign irq = |(stat_ff & mask_ff);

  // ****************************************
  // apb read data
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          `PMRC_OFF_PWR0: prdata <= {30'h0, stop_ff, idle_ff};
          `PMRC_OFF_PWR1: prdata <= {30'h0, snz_ff, susp_ff};
          `PMRC_OFF_REGC: prdata <= {31'h0, sdsel_ff};
          `PMRC_OFF_CLK: prdata <= {31'h0, clksel_ff};
          `PMRC_OFF_RETN: prdata <= {31'h0, retn_ff};
          `PMRC_OFF_STAT: prdata <= {30'h0, stat_ff};
          `PMRC_OFF_MASK: prdata <= {30'h0, mask_ff};
          `PMRC_OFF_SWRST: prdata <= 32'h0000_0000;
          `PMRC_OFF_RSRC: prdata <= {29'h0, rsrc_ff};
          `PMRC_OFF_PGATE: prdata <= 32'(pgate_ff);
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************
  // power and clock outputs
  // ****************************************
  logic lowp, off, in_rst;
  assign lowp = state_ff == PMRC_LOWP;
  assign off = state_ff == PMRC_OFF;
  assign in_rst = state_ff == PMRC_RESET;

  assign core_halt = state_ff != PMRC_RUN; // R1 R8
  assign core_rst = in_rst; // R8
  assign core_clk_gate_n = !(lowp || off); // R3
  assign hfo_first_en = !(lowp || off); // R3
  assign hfo_second_en = !(lowp || off) && clksel_ff;
  assign lfo_timer_en = !off;
  assign reg_low_bias = lowp && snz_ff; // R5
  assign power_nets_off = off; // R6 R7
  assign pin_hold = off; // R6 R7

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_pclk
      // idle keeps peripherals clocked; unused ones stay gated
      assign periph_clk_en[gi] = !(lowp || off || in_rst) && // R15
        (pgate_ff[gi] || periph_busy[gi]);
    end
  endgenerate

  // retention only ever applies after a non-por reset
  assign port_force_default = in_rst && (reset_is_por_ff || !retn_ff);
  assign port_latch_one = port_force_default; // R10
  assign port_open_drain = port_force_default; // R10
  assign port_pullup_en = 1'b1; // R10
  assign retain_analog = retn_ff && !reset_is_por_ff; // R11
  assign reset_pin_n_o = 1'b0;
  assign reset_pin_n_oe = in_rst && reset_drive_ff; // R12
  assign wdt_enable = 1'b1; // R13
  assign pc_reset_value = 16'h0000; // R13
  assign ram_clear = 1'b0; // R9
  assign core_clock_source = clksel_ff; // R13

  // ****************************************
  // checks
  // ****************************************
  AST_IDLE_WAKE: assert property (@(posedge core_clk) disable iff (rst) // R1
    clk_en && state_ff == PMRC_IDLE && any_irq && !any_rst
    |=> state_ff == PMRC_RUN && !idle_ff)
    else $error("idle did not wake on interrupt");
  AST_SUSP_OSC: assert property (@(posedge core_clk) disable iff (rst) // R3
    lowp |-> !hfo_first_en && !hfo_second_en && !core_clk_gate_n)
    else $error("oscillator running in low power");
  AST_LOWP_WAKE: assert property (@(posedge core_clk) disable iff (rst) // R4
    clk_en && lowp && periph_wake && !any_rst |=> state_ff == PMRC_RUN)
    else $error("low power did not wake");
  AST_SNZ_BIAS: assert property (@(posedge core_clk) disable iff (rst) // R5
    reg_low_bias |-> lowp && snz_ff)
    else $error("low bias outside snooze");
  AST_SHUT_STAY: assert property (@(posedge core_clk) disable iff (rst) // R7
    clk_en && off && sdsel_ff && !rst_pin_req |=> off)
    else $error("shutdown left without pin reset");
  AST_STOP_EXIT: assert property (@(posedge core_clk) disable iff (rst) // R6
    clk_en && off && !sdsel_ff && any_rst |=> in_rst)
    else $error("stop did not exit on reset");
  AST_PIN_DRIVE: assert property (@(posedge core_clk) disable iff (rst) // R12
    clk_en && !in_rst && !(off && sdsel_ff) && rst_supply_req
    |=> reset_pin_n_oe)
    else $error("reset pin not driven for supply reset");
  AST_RST_ENTRY: assert property (@(posedge core_clk) disable iff (rst) // R14
    clk_en && rst_wdt_req && !off |=> in_rst && core_halt)
    else $error("watchdog reset not taken");
  AST_PORT_DEF: assert property (@(posedge core_clk) disable iff (rst) // R10
    in_rst && !retn_ff |-> port_latch_one && port_open_drain)
    else $error("ports not defaulted in reset");
endmodule

//--- rtl/pmrc_defs.svh
// constants for the power mode and reset sequencer.
// assumes inclusion by bare name from the package and the bench.
//
// Summary of operation
// R1 - idle bit halts core; any interrupt wakes
// R2 - firmware selects first oscillator before suspend
// R3 - suspend stops clocks, oscillators; normal bias
// R4 - six peripheral events wake suspend and snooze
// R5 - snooze is suspend with low bias regulator
// R6 - stop: clear shutdown select; any reset exits
// R7 - shutdown: select set; pin or power-on exits
// R8 - reset halts core, clears registers, ports, interrupts; a non-por reset keeps the irq mask and status
// R9 - reset leaves on-chip memory contents untouched
// R10 - reset: port latches one, open drain, pull-ups
// R11 - retention keeps port, converter, reference state
// R12 - supply or power-on reset drives pin low
// R13 - exit reset: pc cleared, internal osc, watchdog
// R14 - eight reset sources enter the reset state
// R15 - unused peripheral clocks are gated off
// R16 - low power request bits clear on wake
`ifndef PMRC_DEFS_SVH
`define PMRC_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define PMRC_OFF_PWR0 12'h000
`define PMRC_OFF_PWR1 12'h004
`define PMRC_OFF_REGC 12'h008
`define PMRC_OFF_CLK 12'h00c
`define PMRC_OFF_RETN 12'h010
`define PMRC_OFF_STAT 12'h014
`define PMRC_OFF_MASK 12'h018
`define PMRC_OFF_SWRST 12'h01c
`define PMRC_OFF_RSRC 12'h020
`define PMRC_OFF_PGATE 12'h024

// ****************************************
// field positions
// ****************************************
`define PMRC_PWR0_IDLE 0
`define PMRC_PWR0_STOP 1
`define PMRC_PWR1_SUSP 0
`define PMRC_PWR1_SNZ 1
`define PMRC_REGC_SDSEL 0
`define PMRC_CLK_HFO1 0
`define PMRC_ST_WAKE 0
`define PMRC_ST_RESET 1

// ****************************************
// reset values and timing
// ****************************************
`define PMRC_CLK_RST 2'h0
`define PMRC_PGATE_RST 8'h00
`define PMRC_RST_HOLD_NS 1000
`define PMRC_CLK_NS 50

`endif

//--- rtl/pmrc_pkg.sv
// types for the power mode and reset sequencer.
// assumes nothing beyond the constants header.
package pmrc_pkg;
  `include "pmrc_defs.svh"

  typedef enum logic [2:0] {
    PMRC_RUN = 3'h0,
    PMRC_IDLE = 3'h1,
    PMRC_LOWP = 3'h3,
    PMRC_OFF = 3'h2,
    PMRC_RESET = 3'h6
  } pmrc_state_e;

  typedef enum logic [2:0] {
    PMRC_SRC_POR = 3'h0,
    PMRC_SRC_PIN = 3'h1,
    PMRC_SRC_CMP = 3'h2,
    PMRC_SRC_SW = 3'h3,
    PMRC_SRC_SUPPLY = 3'h4,
    PMRC_SRC_WDT = 3'h5,
    PMRC_SRC_MCD = 3'h6,
    PMRC_SRC_FLASH = 3'h7
  } pmrc_src_e;
endpackage

//--- rtl/pmrc_hold_cnt.sv
// reset hold counter: counts while run is high, done when terminal.
// assumes a single synchronous clock domain.
`timescale 1ns/1ps
module pmrc_hold_cnt #(
  parameter int CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic run,
  output logic done
);
  logic [15:0] cnt_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 16'h0000;
    end else if (clk_en) begin
      if (!run) begin
        cnt_ff <= 16'h0000;
      end else if (cnt_ff != 16'(CYCLES)) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end

  assign done = run && (cnt_ff == 16'(CYCLES));
endmodule

//--- dv/pmrc_top_bench.sv
// self-checking bench for the power mode and reset sequencer.
// assumes rtl/ on the include path; apb slave with zero wait states.
`timescale 1ns/1ps
`include "pmrc_defs.svh"
module pmrc_top_bench;
  import pmrc_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic core_clk = 0;
  logic rst = 1;
  logic clk_en = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic any_irq = 0;
  logic cmp0_out = 1;
  logic [4:0] wk = 5'h00;
  logic [5:0] rq = 6'h00;
  logic [7:0] periph_busy = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, irq, core_halt, core_rst, core_clk_gate_n;
  logic hfo_first_en, hfo_second_en, lfo_timer_en, reg_low_bias;
  logic power_nets_off, pin_hold, port_force_default, port_latch_one;
  logic port_open_drain, port_pullup_en, retain_analog, reset_pin_n_o;
  logic reset_pin_n_oe, wdt_enable, ram_clear, core_clock_source;
  logic [7:0] periph_clk_en;
  logic [15:0] pc_reset_value;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int checks = 0;

  always #25 core_clk = ~core_clk;

  // short hold keeps the run brief; expectations never count it
  pmrc_top #(.HOLD_CYCLES(2)) pmrc_top_i (
    .core_clk, .rst, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .any_irq,
    .wake_tmr4(wk[0]), .wake_spi(wk[1]), .wake_i2c(wk[2]),
    .wake_port_match(wk[3]), .cmp0_out, .wake_clu(wk[4]),
    .rst_pin_req(rq[0]), .rst_cmp_req(rq[1]), .rst_supply_req(rq[2]),
    .rst_wdt_req(rq[3]), .rst_mcd_req(rq[4]), .rst_flash_req(rq[5]),
    .periph_busy, .core_halt, .core_rst, .core_clk_gate_n,
    .periph_clk_en, .hfo_first_en, .hfo_second_en, .lfo_timer_en,
    .reg_low_bias, .power_nets_off, .pin_hold, .port_force_default,
    .port_latch_one, .port_open_drain, .port_pullup_en, .retain_analog,
    .reset_pin_n_o, .reset_pin_n_oe, .wdt_enable, .pc_reset_value,
    .ram_clear, .core_clock_source
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task timeout;
    bad_count++;
    $display("ERROR wait limit expected 1 seen 0");
    final_report;
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  // request held until pready is sampled high, then released
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timeout;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(n, rd, e);
  endtask

  task settle(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask

  // which: 0 watches core_rst, 1 watches core_halt
  task wait_sig(input int which, input logic v);
    int n;
    n = 0;
    while (((which == 0) ? core_rst : core_halt) !== v && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 40) timeout;
  endtask

  task pulse(input int idx);
    @(posedge core_clk);
    rq[idx] <= 1;
    @(posedge core_clk);
    rq[idx] <= 0;
  endtask

  task por;
    @(posedge core_clk);
    rst <= 1;
    settle(3);
    chk("core_rst", core_rst, 1);
    chk("latch", {port_latch_one, port_open_drain, port_pullup_en}, 7);
    chk("force", port_force_default, 1);
    chk("pin_oe", {reset_pin_n_oe, reset_pin_n_o}, 2);
    chk("retain", retain_analog, 0);
    @(posedge core_clk);
    rst <= 0;
    wait_sig(0, 0);
    chk("exit", {wdt_enable, core_clock_source, ram_clear}, 4);
    chk("pc", pc_reset_value, 0);
    chk("pullup", port_pullup_en, 1);
    rdchk("status", `PMRC_OFF_STAT, 2);
    rdchk("src", `PMRC_OFF_RSRC, 0);
  endtask

  // code: 1 pin 2 cmp 3 sw 4 supply 5 wdt 6 mcd 7 flash
  task rsrc(input int i);
    if (i == 3) begin
      apb(1, `PMRC_OFF_SWRST, 32'h1);
    end else begin
      pulse(i - 1 - ((i > 3) ? 1 : 0));
    end
    wait_sig(0, 1);
    chk("pin_oe", reset_pin_n_oe, i == 4);
    chk("halt", {core_halt, port_force_default}, 3);
    wait_sig(0, 0);
    rdchk("src", `PMRC_OFF_RSRC, i);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    por;
    apb(0, 12'hffc, 32'h0);
    chk("slverr", err, 1);
    apb(0, `PMRC_OFF_PWR0, 32'h0);
    chk("slverr_ok", err, 0);
    $display("test reset done");

    apb(1, `PMRC_OFF_MASK, 32'h3);
    apb(1, `PMRC_OFF_PGATE, 32'h5);
    apb(1, `PMRC_OFF_PWR0, 32'h1);
    settle(3);
    chk("idle", {core_halt, core_clk_gate_n, irq}, 6);
    chk("idle_pclk", periph_clk_en, 8'h05);
    @(posedge core_clk);
    periph_busy <= 8'h80;
    settle(1);
    chk("busy_pclk", periph_clk_en, 8'h85);
    @(posedge core_clk);
    any_irq <= 1;
    wait_sig(1, 0);
    @(posedge core_clk);
    any_irq <= 0;
    rdchk("pwr0", `PMRC_OFF_PWR0, 0);
    settle(1);
    chk("irq", irq, 1);
    apb(1, `PMRC_OFF_MASK, 32'h0);
    settle(1);
    chk("irq_mask", irq, 0);
    rdchk("status", `PMRC_OFF_STAT, 1);
    apb(1, `PMRC_OFF_MASK, 32'h1);
    settle(1);
    chk("irq_clr", irq, 0);
    @(posedge core_clk);
    clk_en <= 0;
    apb(1, `PMRC_OFF_PWR0, 32'h1);
    settle(2);
    chk("freeze_halt", core_halt, 0);
    @(posedge core_clk);
    clk_en <= 1;
    rdchk("freeze_pwr0", `PMRC_OFF_PWR0, 0);
    $display("test idle done");

    apb(1, `PMRC_OFF_CLK, 32'h1);
    apb(1, `PMRC_OFF_PWR1, 32'h1);
    settle(3);
    chk("refused", {core_halt, hfo_second_en, core_clock_source}, 3);
    apb(1, `PMRC_OFF_CLK, 32'h0);
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 6; s++) begin
        apb(1, `PMRC_OFF_PWR1, (m == 1) ? 32'h2 : 32'h1);
        settle(3);
        chk("halt", {core_halt, core_clk_gate_n}, 2);
        chk("osc", {hfo_first_en, hfo_second_en, lfo_timer_en}, 1);
        chk("bias", reg_low_bias, m);
        chk("pclk", periph_clk_en, 0);
        @(posedge core_clk);
        if (s == 5) begin
          cmp0_out <= 0;
        end else begin
          wk[s] <= 1;
        end
        wait_sig(1, 0);
        @(posedge core_clk);
        cmp0_out <= 1;
        wk <= 5'h00;
        rdchk("pwr1", `PMRC_OFF_PWR1, 0);
      end
    end
    $display("test suspend done");

    for (int i = 1; i < 8; i++) begin
      if (i != 3) begin
        apb(1, `PMRC_OFF_REGC, 32'h0);
        apb(1, `PMRC_OFF_PWR0, 32'h2);
        settle(3);
        chk("stop", {power_nets_off, pin_hold, lfo_timer_en,
                     core_clk_gate_n}, 4'hc);
      end
      rsrc(i);
    end
    apb(1, `PMRC_OFF_REGC, 32'h1);
    apb(1, `PMRC_OFF_PWR0, 32'h2);
    pulse(3);
    settle(5);
    chk("shut", {power_nets_off, pin_hold, core_rst}, 6);
    rsrc(1);
    $display("test stop done");

    apb(1, `PMRC_OFF_RETN, 32'h1);
    pulse(3);
    wait_sig(0, 1);
    chk("keep", {port_force_default, retain_analog}, 1);
    wait_sig(0, 0);
    por;
    $display("test retention done");
    final_report;
  end
endmodule
